/* rtl/dsc_pkg.sv */
// package: constants and types for the dac sequencer conversion control block
// Function
// - per-block conversion count; zero means convert continuously without stopping.
// - fifo fill level is presented to software as a readable value.
// - whenever fifo holds data, a data set preloads all participating dacs. The logic stops preloading once an error is set or it halts.
// - normal mode issues no pulses until software sets the start bit.
// - after start wait rising clock edge, then pulse each period from falling edge.
// - active flag sets on start write and clears on last conversion.
// - after each pulse the next set is sent, waiting on empty fifo.
// - preload flag sets when a set is transferred, clears at next pulse.
// - timing error when a due pulse would break dac minimum timing.
// - data error when a pulse is due and preload is incomplete.
// - any timing, data or frame error halts the sequencer, no more pulses.
// - frame mode takes conversions per frame and interval; zero means continuous. i_frame_interval is not used by the logic.
// - frame mode waits for trigger, then pulses from next conversion clock event.
// - frame end clears active, next trigger restarts automatically.
// - outside continuous mode, trigger before frame completes raises a frame error.
// - multi-board: master drives trigger and clock; all boards take pin inputs.
// - nonzero length write while idle starts fetch; write only after completion. This block has no length register or fetch logic.
// - set is four 16-bit words per dac, by device then channel.
`default_nettype none
package dsc_pkg;
  localparam int unsigned DSC_NUM_DACS      = 2;
  localparam int unsigned DSC_CH_PER_DAC    = 4;
  localparam int unsigned DSC_WORDS_PER_SET = DSC_NUM_DACS * DSC_CH_PER_DAC;
  localparam int unsigned DSC_CNT_W         = 16;
  localparam int unsigned DSC_LVL_W         = 12;
  localparam logic [DSC_CNT_W-1:0] DSC_CNT_RST = 16'h0000;
  // minimum spacing between two pulses required by the dacs
  localparam int unsigned DSC_MIN_GAP_NS   = 25000;
  localparam int unsigned DSC_CLK_NS       = 10;
  localparam int unsigned DSC_MIN_GAP_CYC  = (DSC_MIN_GAP_NS + DSC_CLK_NS - 1) / DSC_CLK_NS;
  localparam int unsigned DSC_GAP_W        = 16;
  localparam logic [DSC_GAP_W-1:0] DSC_GAP_RST = 16'h0000;

  typedef enum logic [1:0] {DSC_MODE_OFF, DSC_MODE_NORMAL, DSC_MODE_FRAME} dsc_mode_t;

  typedef struct packed {
    logic [15:0] word;
    logic        valid;
  } dsc_data_t;

  typedef struct packed {
    logic active;
    logic preload;
    logic err_timing;
    logic err_data;
    logic err_frame;
  } dsc_status_t;
endpackage : dsc_pkg
`default_nettype wire

/* rtl/dsc_sync.sv */
// two flip-flop level synchroniser
`default_nettype none
module dsc_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;
  logic sync_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule : dsc_sync
`default_nettype wire

/* rtl/dsc_ctrl.sv */
// conversion control: preload, pulse sequencing and error detection
`default_nettype none
module dsc_ctrl
  import dsc_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  input  var  dsc_mode_t            i_mode,
  input  wire logic [DSC_CNT_W-1:0] i_num_conv,
  input  wire logic [DSC_CNT_W-1:0] i_frame_interval,
  input  wire logic                 i_start,
  input  wire logic                 i_conv_clk_pin,
  input  wire logic                 i_frame_trig_pin,
  input  var  dsc_data_t            i_fifo_data,
  input  wire logic [DSC_LVL_W-1:0] i_fifo_level,
  output logic                      o_fifo_ready,
  output dsc_data_t                 o_dac_data,
  output logic [0:0]                o_dac_sel,
  output logic [1:0]                o_dac_ch,
  output logic                      o_dac_load,
  input  wire logic                 i_dac_ready,
  output logic                      o_dac_conv_pulse,
  output logic [DSC_LVL_W-1:0]      o_fifo_level,
  output dsc_status_t               o_status
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection
  logic start_s;
  logic cclk_s;
  logic trig_s;
  dsc_sync u_sync_start (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_start),
                         .o_sync(start_s));
  dsc_sync u_sync_cclk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_conv_clk_pin),
                        .o_sync(cclk_s));
  dsc_sync u_sync_trig (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_frame_trig_pin),
                        .o_sync(trig_s));

  logic start_d_reg;
  logic cclk_d_reg;
  logic trig_d_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      start_d_reg <= 1'b0;
      cclk_d_reg  <= 1'b0;
      trig_d_reg  <= 1'b0;
    end else begin
      start_d_reg <= start_s;
      cclk_d_reg  <= cclk_s;
      trig_d_reg  <= trig_s;
    end
  end

  wire start_rise = start_s & ~start_d_reg;
  wire cclk_rise  = cclk_s & ~cclk_d_reg;
  wire cclk_fall  = ~cclk_s & cclk_d_reg;
  wire trig_rise  = trig_s & ~trig_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  typedef enum logic [1:0] {DSC_IDLE, DSC_ARM, DSC_RUN, DSC_HALT} dsc_state_t;
  dsc_state_t state_reg;
  dsc_state_t state_next;

  logic [DSC_CNT_W-1:0] done_reg;
  logic [DSC_GAP_W-1:0] gap_reg;
  logic                 active_reg;
  logic                 preload_reg;
  logic                 err_t_reg;
  logic                 err_d_reg;
  logic                 err_f_reg;
  logic [2:0]           widx_reg;
  logic                 loading_reg;

  // one shared increment keeps the compare and the counter on the same width
  function automatic logic [DSC_CNT_W-1:0] dsc_inc(input logic [DSC_CNT_W-1:0] v);
    return v + DSC_CNT_W'(1);
  endfunction : dsc_inc

  wire is_normal  = (i_mode == DSC_MODE_NORMAL);
  wire is_frame   = (i_mode == DSC_MODE_FRAME);
  wire continuous = (i_num_conv == DSC_CNT_RST);
  wire any_err    = err_t_reg | err_d_reg | err_f_reg;

  // frame mode fires on the rising edge (first event after trigger); normal on falling
  wire pulse_due  = (state_reg == DSC_RUN) &&
                    (is_normal ? cclk_fall : cclk_rise);
  wire gap_ok     = (gap_reg >= DSC_GAP_W'(DSC_MIN_GAP_CYC));
  wire timing_bad = pulse_due & ~gap_ok;
  wire data_bad   = pulse_due & gap_ok & ~preload_reg;
  wire fire       = pulse_due & gap_ok & preload_reg;
  wire last_conv  = fire & ~continuous &
                    (dsc_inc(done_reg) == i_num_conv);
  wire frame_bad  = is_frame & trig_rise & ~continuous &
                    (state_reg == DSC_RUN);
  wire new_err    = timing_bad | data_bad | frame_bad;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DSC_IDLE: begin
        if (is_normal && start_rise) state_next = DSC_ARM;
        else if (is_frame && trig_rise) state_next = DSC_RUN;
      end
      DSC_ARM:  if (cclk_rise) state_next = DSC_RUN;
      DSC_RUN: begin
        if (new_err) state_next = DSC_HALT;
        else if (last_conv) state_next = DSC_IDLE;
      end
      DSC_HALT: state_next = DSC_HALT;
    endcase
    if (i_mode == DSC_MODE_OFF) state_next = DSC_IDLE;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= DSC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion counting, gap timer and flags
  // errors are sticky until reset or mode off: halting must be visible to software
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_mode == DSC_MODE_OFF) begin
      done_reg   <= DSC_CNT_RST;
      active_reg <= 1'b0;
      err_t_reg  <= 1'b0;
      err_d_reg  <= 1'b0;
      err_f_reg  <= 1'b0;
    end else begin
      if (state_reg == DSC_IDLE && state_next != DSC_IDLE) begin
        done_reg   <= DSC_CNT_RST;
        active_reg <= 1'b1;
      end else if (fire) begin
        done_reg <= dsc_inc(done_reg);
      end
      if (last_conv || new_err) active_reg <= 1'b0;
      if (timing_bad) err_t_reg <= 1'b1;
      if (data_bad) err_d_reg <= 1'b1;
      if (frame_bad) err_f_reg <= 1'b1;
    end
  end

  // gap timer starts saturated so the first pulse is never a timing error
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      gap_reg <= ~DSC_GAP_RST;
    end else if (fire) begin
      gap_reg <= DSC_GAP_RST;
    end else if (gap_reg != ~DSC_GAP_RST) begin
      gap_reg <= gap_reg + DSC_GAP_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // preload: one data set of four words per dac, device then channel order
  wire can_load = ~preload_reg & ~any_err & (state_reg != DSC_HALT);
  wire take     = can_load & i_fifo_data.valid & i_dac_ready;
  wire set_done = take & (widx_reg == 3'(DSC_WORDS_PER_SET - 1));

  assign o_fifo_ready = can_load & i_dac_ready;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      widx_reg    <= 3'h0;
      preload_reg <= 1'b0;
      loading_reg <= 1'b0;
      o_dac_data  <= '0;
      o_dac_sel   <= 1'h0;
      o_dac_ch    <= 2'h0;
    end else begin
      loading_reg <= take;
      if (take) begin
        o_dac_data <= i_fifo_data;
        o_dac_sel  <= widx_reg[2];
        o_dac_ch   <= widx_reg[1:0];
        widx_reg   <= set_done ? 3'h0 : widx_reg + 3'h1;
      end else begin
        o_dac_data.valid <= 1'b0;
      end
      // set wins over clear: a set completing on a pulse cycle keeps the flag
      if (set_done) preload_reg <= 1'b1;
      else if (fire) preload_reg <= 1'b0;
    end
  end
  assign o_dac_load = loading_reg;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic pulse_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pulse_reg    <= 1'b0;
      o_fifo_level <= '0;
    end else begin
      pulse_reg    <= fire;
      o_fifo_level <= i_fifo_level;
    end
  end
  assign o_dac_conv_pulse   = pulse_reg;
  // one driver for the whole status word
  assign o_status = '{active:     active_reg,
                      preload:    preload_reg,
                      err_timing: err_t_reg,
                      err_data:   err_d_reg,
                      err_frame:  err_f_reg};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fire;
    fire;
  endsequence
  sequence s_pulse_out;
    ##1 o_dac_conv_pulse;
  endsequence

  property p_pulse_follows;
    @(posedge i_sys_clk) disable iff (i_srst) s_fire |-> s_pulse_out;
  endproperty
  a_pulse_follows: assert property (p_pulse_follows) else $error("pulse missing");

  property p_no_pulse_idle;
    @(posedge i_sys_clk) disable iff (i_srst)
      (state_reg != DSC_RUN) |-> ##1 !o_dac_conv_pulse;
  endproperty
  a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("pulse while idle");

  property p_halt_stops;
    @(posedge i_sys_clk) disable iff (i_srst) any_err |-> !fire;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("pulse after error");

  property p_gap;
    @(posedge i_sys_clk) disable iff (i_srst) fire |-> gap_reg >= DSC_GAP_W'(DSC_MIN_GAP_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("pulse too close");

  property p_data_err;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (pulse_due && gap_ok && !preload_reg) |=> err_d_reg && !active_reg;
  endproperty
  a_data_err: assert property (p_data_err) else $error("data error missed");

  property p_preload_clear;
    @(posedge i_sys_clk) disable iff (i_srst) (fire && !set_done) |=> !preload_reg;
  endproperty
  a_preload_clear: assert property (p_preload_clear) else $error("preload kept");

  property p_last;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (last_conv && !new_err) |=> !active_reg && state_reg == DSC_IDLE;
  endproperty
  a_last: assert property (p_last) else $error("active after last");

  property p_frame_err;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      frame_bad |=> err_f_reg && state_reg == DSC_HALT;
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("frame error missed");

  property p_cont;
    @(posedge i_sys_clk) disable iff (i_srst) (fire && continuous) |-> !last_conv;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous stopped");

  ////////////////////////////////////////////////////////////////////////////
  // preload path and flag checks
  sequence s_take;
    take;
  endsequence
  sequence s_word_out;
    ##1 (o_dac_load && o_dac_data.valid);
  endsequence

  property p_word_follows;
    @(posedge i_sys_clk) disable iff (i_srst) s_take |-> s_word_out;
  endproperty
  a_word_follows: assert property (p_word_follows) else $error("word not sent");

  property p_word_order;
    @(posedge i_sys_clk) disable iff (i_srst)
      take |=> {o_dac_sel, o_dac_ch} == $past(widx_reg);
  endproperty
  a_word_order: assert property (p_word_order) else $error("word order wrong");

  property p_set_marks;
    @(posedge i_sys_clk) disable iff (i_srst) set_done |=> preload_reg;
  endproperty
  a_set_marks: assert property (p_set_marks) else $error("preload not set");

  property p_no_load_full;
    @(posedge i_sys_clk) disable iff (i_srst) preload_reg |-> !o_fifo_ready;
  endproperty
  a_no_load_full: assert property (p_no_load_full) else $error("load while full");

  property p_level;
    @(posedge i_sys_clk) disable iff (i_srst) !i_srst |=> o_fifo_level == $past(i_fifo_level);
  endproperty
  a_level: assert property (p_level) else $error("fill level stale");

  property p_active_set;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (state_reg == DSC_IDLE && state_next != DSC_IDLE) |=> active_reg;
  endproperty
  a_active_set: assert property (p_active_set) else $error("active not set");

  property p_timing_err;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      timing_bad |=> err_t_reg && state_reg == DSC_HALT;
  endproperty
  a_timing_err: assert property (p_timing_err) else $error("timing error missed");

  property p_err_inactive;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      new_err |=> !active_reg;
  endproperty
  a_err_inactive: assert property (p_err_inactive) else $error("active after error");

  property p_halt_hold;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (state_reg == DSC_HALT) |=> (state_reg == DSC_HALT);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt");

  property p_frame_wait;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (is_frame && state_reg == DSC_IDLE && !trig_rise) |=> (state_reg == DSC_IDLE);
  endproperty
  a_frame_wait: assert property (p_frame_wait) else $error("frame ran early");

  property p_normal_falls;
    @(posedge i_sys_clk) disable iff (i_srst) (fire && is_normal) |-> cclk_fall;
  endproperty
  a_normal_falls: assert property (p_normal_falls) else $error("normal pulse edge");

  property p_frame_rises;
    @(posedge i_sys_clk) disable iff (i_srst) (fire && is_frame) |-> cclk_rise;
  endproperty
  a_frame_rises: assert property (p_frame_rises) else $error("frame pulse edge");

  property p_cont_active;
    @(posedge i_sys_clk) disable iff (i_srst || i_mode == DSC_MODE_OFF)
      (fire && continuous) |=> active_reg;
  endproperty
  a_cont_active: assert property (p_cont_active) else $error("continuous ended");
endmodule : dsc_ctrl
`default_nettype wire

/* testbench/dsc_dac_model.sv */
// dac model: two serial dacs that take one word at a time and may stall between words
`default_nettype none
module dsc_dac_model
  import dsc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic       i_slow,
  input  var  dsc_data_t  i_data,
  input  wire logic       i_load,
  input  wire logic [0:0] i_sel,
  input  wire logic [1:0] i_ch,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] chan_reg [DSC_WORDS_PER_SET];
  logic [3:0]  busy_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // a word holds the bus while it shifts; slow mode stretches that like a long frame
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      busy_reg <= 4'h0;
    end else if (i_load) begin
      chan_reg[{i_sel, i_ch}] <= i_data.word;
      busy_reg <= i_slow ? 4'hF : 4'h1;
    end else if (busy_reg != 4'h0) begin
      busy_reg <= busy_reg - 4'h1;
    end
  end
  assign o_ready = (busy_reg == 4'h0);
endmodule : dsc_dac_model
`default_nettype wire

/* testbench/dsc_ctrl_bench.sv */
// bench: conversion control block against a fifo feeder and the dac model
`default_nettype none
module dsc_ctrl_bench
  import dsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 start = 1'b0;
  logic                 cc_pin = 1'b0;
  logic                 trig = 1'b0;
  logic                 slow = 1'b0;
  logic                 took = 1'b0;
  logic                 lvl_chk = 1'b0;
  dsc_mode_t            mode = DSC_MODE_OFF;
  logic [DSC_CNT_W-1:0] num_conv = 16'h0000;
  dsc_data_t            fifo_data = '0;
  logic [DSC_LVL_W-1:0] lvl_in = 12'h000;
  logic [DSC_LVL_W-1:0] lvl_prev = 12'h000;
  logic [DSC_LVL_W-1:0] lvl_out;
  dsc_data_t            dac_data;
  dsc_status_t          st;
  logic                 fifo_ready, dac_load, dac_ready, pulse;
  logic [0:0]           dac_sel;
  logic [1:0]           dac_ch;
  logic [15:0]          fifo_q[$];
  logic [18:0]          exp_q[$];
  int                   n_fail = 0, total_checks = 0, n_pulse = 0, last_pulse = 0;
  int                   cyc = 0, cc_half = 1300, n_seen = 0;

  dsc_ctrl u_dut (.i_sys_clk(clk), .i_srst(srst), .i_mode(mode), .i_num_conv(num_conv),
    .i_frame_interval(16'h0040), .i_start(start), .i_conv_clk_pin(cc_pin),
    .i_frame_trig_pin(trig), .i_fifo_data(fifo_data), .i_fifo_level(lvl_in),
    .o_fifo_ready(fifo_ready), .o_dac_data(dac_data), .o_dac_sel(dac_sel), .o_dac_ch(dac_ch),
    .o_dac_load(dac_load), .i_dac_ready(dac_ready), .o_dac_conv_pulse(pulse),
    .o_fifo_level(lvl_out), .o_status(st));
  dsc_dac_model u_dac (.i_sys_clk(clk), .i_srst(srst), .i_slow(slow), .i_data(dac_data),
    .i_load(dac_load), .i_sel(dac_sel), .i_ch(dac_ch), .o_ready(dac_ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_vec(input string what, input logic [18:0] exp, input logic [18:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec
  task automatic chk_num(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_num
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic push_set(input int n);
    logic [15:0] w;
    for (int s = 0; s < n; s++) begin
      for (int i = 0; i < DSC_WORDS_PER_SET; i++) begin
        w = 16'($urandom);
        fifo_q.push_back(w);
        exp_q.push_back({i[2], i[1:0], w});
      end
    end
  endtask : push_set
  task automatic drain(input int lim);
    for (int i = 0; i < lim && exp_q.size() > 0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : drain
  task automatic wait_pulses(input int n, input int lim);
    for (int i = 0; i < lim && n_pulse < n; i++) @(negedge clk);
  endtask : wait_pulses
  // the fifo is emptied first so an error state cannot leave a half-taken set behind
  task automatic restart(input dsc_mode_t m, input logic [DSC_CNT_W-1:0] n);
    fifo_q.delete();
    repeat (3) @(negedge clk);
    exp_q.delete();
    mode = DSC_MODE_OFF;
    repeat (4) @(negedge clk);
    n_pulse = 0;
    num_conv = n;
    mode = m;
    push_set(1);
    drain(400);
  endtask : restart
  task automatic kick();
    start = 1'b1;
    repeat (6) @(negedge clk);
    chk_bit("active", 1'b1, st.active);
    start = 1'b0;
  endtask : kick
  // trigger placed 100 cycles into the low phase, locked to the conversion clock as the sources must be
  task automatic frame_trig();
    @(negedge cc_pin);
    repeat (100) @(negedge clk);
    trig = 1'b1;
    repeat (60) @(negedge clk);
    trig = 1'b0;
  endtask : frame_trig
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (cc_half) @(negedge clk);
      cc_pin <= ~cc_pin;
    end
  end
  always @(posedge clk) begin
    cyc++;
    took <= fifo_data.valid & fifo_ready;
  end
  always @(negedge clk) begin
    if (took && fifo_q.size() > 0) void'(fifo_q.pop_front());
    fifo_data.valid = (fifo_q.size() > 0);
    fifo_data.word = (fifo_q.size() > 0) ? fifo_q[0] : 16'h0000;
    lvl_in = DSC_LVL_W'($urandom);
  end
  always @(posedge clk) begin
    if (lvl_chk) chk_vec("fifo level", {7'h00, lvl_prev}, {7'h00, lvl_out});
    lvl_prev <= lvl_in;
    if (!srst && dac_load) begin
      if (exp_q.size() == 0) chk_num("spare word", 0, 1);
      else chk_vec("word", exp_q.pop_front(), {dac_sel, dac_ch, dac_data.word});
    end
    if (!srst && pulse) begin
      if (n_pulse > 0) chk_num("pulse gap", 0, (cyc - last_pulse) % (2 * cc_half));
      n_pulse++;
      last_pulse = cyc;
    end
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32'h3369));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    restart(DSC_MODE_NORMAL, 16'h0003);
    lvl_chk = 1'b1;
    chk_bit("preload", 1'b1, st.preload);
    push_set(3);
    repeat (2700) @(negedge clk);
    chk_num("pulses before start", 0, n_pulse);
    lvl_chk = 1'b0;
    kick();
    wait_pulses(3, 12000);
    repeat (6) @(negedge clk);
    chk_bit("active end", 1'b0, st.active);
    drain(400);
    chk_bit("preload next", 1'b1, st.preload);
    repeat (3000) @(negedge clk);
    chk_num("no restart", 3, n_pulse);
    num_conv = 16'h0001;
    push_set(1);
    kick();
    wait_pulses(4, 6000);
    repeat (3000) @(negedge clk);
    chk_num("second block", 4, n_pulse);
    $display("test normal block done");
    restart(DSC_MODE_NORMAL, 16'h0000);
    // mode off keeps the loaded set, so four queued sets run dry at the sixth pulse
    push_set(3);
    kick();
    wait_pulses(5, 16000);
    chk_bit("active continuous", 1'b1, st.active);
    repeat (3000) @(negedge clk);
    chk_bit("data error", 1'b1, st.err_data);
    n_seen = n_pulse;
    repeat (3000) @(negedge clk);
    chk_num("halt on data error", n_seen, n_pulse);
    $display("test continuous done");
    cc_half = 100;
    restart(DSC_MODE_NORMAL, 16'h0003);
    push_set(3);
    kick();
    repeat (1000) @(negedge clk);
    chk_bit("timing error", 1'b1, st.err_timing);
    n_seen = n_pulse;
    repeat (1000) @(negedge clk);
    chk_num("halt on timing error", n_seen, n_pulse);
    $display("test timing done");
    cc_half = 1300;
    slow = 1'b1;
    restart(DSC_MODE_FRAME, 16'h0002);
    push_set(6);
    repeat (2700) @(negedge clk);
    chk_num("pulses before trigger", 0, n_pulse);
    frame_trig();
    wait_pulses(2, 8000);
    repeat (2700) @(negedge clk);
    chk_num("frame pulses", 2, n_pulse);
    chk_bit("active frame end", 1'b0, st.active);
    frame_trig();
    wait_pulses(4, 8000);
    chk_num("second frame", 4, n_pulse);
    frame_trig();
    wait_pulses(5, 4000);
    frame_trig();
    repeat (3000) @(negedge clk);
    chk_bit("frame error", 1'b1, st.err_frame);
    n_seen = n_pulse;
    repeat (3000) @(negedge clk);
    chk_num("halt on frame error", n_seen, n_pulse);
    $display("test frame done");
    close_out();
  end
endmodule : dsc_ctrl_bench
`default_nettype wire
